// ---- rtl/timer16_defines.vh ----
// register map, field positions, reset values and mode codes
// for the 16-bit timer waveform control block; definitions only
`ifndef TIMER16_DEFINES_VH
`define TIMER16_DEFINES_VH

`define ADDR_CTRL_A 8'h80
`define ADDR_CTRL_B 8'h81
`define ADDR_COUNT 8'h84
`define ADDR_CAPTURE 8'h86
`define ADDR_CMP_A 8'h88
`define ADDR_CMP_B 8'h8A
`define ADDR_INT_STAT 8'h8C
`define ADDR_INT_MASK 8'h8D
`define ADDR_RUN 8'h8E

`define CTRL_A_RESET 8'h00
`define CTRL_B_RESET 8'h00
`define WORD_RESET 16'h0000
`define INT_RESET 4'h0

`define COM_A_MSB 7
`define COM_A_LSB 6
`define COM_B_MSB 5
`define COM_B_LSB 4
`define WGM_LO_MSB 1
`define WGM_LO_LSB 0
`define WGM_HI_MSB 4
`define WGM_HI_LSB 3
`define RUN_BIT 0

`define INT_OVF 0
`define INT_MATCH_A 1
`define INT_MATCH_B 2
`define INT_TOP 3

`define TOP_MAX 16'hFFFF
`define TOP_8BIT 16'h00FF
`define TOP_9BIT 16'h01FF
`define TOP_10BIT 16'h03FF
`define BOTTOM 16'h0000

`define MODE_NORMAL 4'h0
`define MODE_PC8 4'h1
`define MODE_PC9 4'h2
`define MODE_PC10 4'h3
`define MODE_CTC_CMP 4'h4
`define MODE_FAST8 4'h5
`define MODE_FAST9 4'h6
`define MODE_FAST10 4'h7
`define MODE_PFC_CAP 4'h8
`define MODE_PFC_CMP 4'h9
`define MODE_PC_CAP 4'hA
`define MODE_PC_CMP 4'hB
`define MODE_CTC_CAP 4'hC
`define MODE_RESERVED 4'hD
`define MODE_FAST_CAP 4'hE
`define MODE_FAST_CMP 4'hF

`endif

// ---- rtl/timer16_waveform_mode_control.v ----
// 16-bit timer: waveform mode control, counter, compare outputs
// assumes a single-cycle register port and synchronous pin inputs
//
// Overview of operation
// - channel A output mode 10/11, or 01 where A may toggle, puts compare output A on its pin
// - channel B output mode 10/11, or 01 in non-PWM modes, puts compare output B on its pin
// - pin driver enabled only by the pin's data direction bit
// - non-PWM: 00 off, 01 toggle, 10 clear, 11 set on match
// - fast PWM code 01 toggles A only in modes 14/15; B stays off
// - fast PWM: 10 clears on match, sets at TOP; 11 the reverse
// - fast PWM 10/11: match at TOP ignored, TOP action still done; 01 toggles on a match at TOP
// - dual-slope code 01 toggles A only in modes 8 to 11
// - dual-slope: 10 clears on up match, sets on down; 11 reverse
// - control A bits 3:2 read zero, writes ignored
// - two low mode bits plus two high bits form the 4-bit mode
// - modes 0, 4, 12: normal/clear-on-match, immediate, flag at MAX
// - modes 1-3 phase correct 8/9/10-bit, reload TOP, flag BOTTOM
// - modes 8,9 reload and flag BOTTOM; 10,11 reload TOP
// - modes 5-7, 14, 15 fast PWM, reload and flag at TOP
// - upper mode bits sit at control B bits 4:3
`timescale 1ns/1ps
`include "timer16_defines.vh"

module timer16_waveform_mode_control (
    input wire clk,
    input wire nrst,
    input wire [7:0] addr,
    input wire [15:0] wdata,
    input wire wr_en,
    input wire rd_en,
    output reg [15:0] rdata,
    input wire dir_a,
    input wire dir_b,
    input wire port_a_out,
    input wire port_b_out,
    output wire pin_a_out,
    output wire pin_a_oe,
    output wire pin_b_out,
    output wire pin_b_oe,
    output reg compare_out_a,
    output reg compare_out_b,
    output wire irq
);

localparam CLS_NONPWM = 2'b00;
localparam CLS_FAST = 2'b01;
localparam CLS_DUAL = 2'b10;

// registers
reg [1:0] chan_a_output_mode;
reg [1:0] chan_b_output_mode;
reg [1:0] wgm_lo_reg;
reg [1:0] wgm_hi_reg;
reg run_reg;
reg [15:0] counter_value;
reg count_up_reg;
reg block_reg;
reg [15:0] compare_value_a;
reg [15:0] compare_value_b;
reg [15:0] cmp_buf_a_reg;
reg [15:0] cmp_buf_b_reg;
reg [15:0] capture_value;
reg [3:0] int_stat_reg;
reg [3:0] int_mask_reg;

wire [3:0] waveform_mode_sel;
wire [1:0] cls;
wire [15:0] top;
wire at_top;
wire at_bottom;
wire top_evt;
wire bottom_evt;
wire max_evt;
wire overflow_flag;
wire reload;
wire up_eff;
wire match_a;
wire match_b;
wire allow_a;
wire allow_b;
wire conn_a;
wire conn_b;
wire wr_ctrl_a;
wire wr_ctrl_b;
wire wr_count;
wire wr_cmp_a;
wire wr_cmp_b;
wire [3:0] int_evt;

// mode code to counting class
function [1:0] mode_class;
    input [3:0] m;
    begin
        case (m)
            `MODE_FAST8, `MODE_FAST9, `MODE_FAST10,
            `MODE_FAST_CAP, `MODE_FAST_CMP:
                mode_class = CLS_FAST;
            `MODE_PC8, `MODE_PC9, `MODE_PC10,
            `MODE_PFC_CAP, `MODE_PFC_CMP,
            `MODE_PC_CAP, `MODE_PC_CMP:
                mode_class = CLS_DUAL;
            default:
                mode_class = CLS_NONPWM;
        endcase
    end
endfunction

// TOP value selected by the mode
function [15:0] mode_top;
    input [3:0] m;
    input [15:0] cmp_a;
    input [15:0] cap;
    begin
        case (m)
            `MODE_PC8, `MODE_FAST8:
                mode_top = `TOP_8BIT;
            `MODE_PC9, `MODE_FAST9:
                mode_top = `TOP_9BIT;
            `MODE_PC10, `MODE_FAST10:
                mode_top = `TOP_10BIT;
            `MODE_CTC_CMP, `MODE_PFC_CMP,
            `MODE_PC_CMP, `MODE_FAST_CMP:
                mode_top = cmp_a;
            `MODE_CTC_CAP, `MODE_PFC_CAP,
            `MODE_PC_CAP, `MODE_FAST_CAP:
                mode_top = cap;
            default:
                mode_top = `TOP_MAX;
        endcase
    end
endfunction

// whether code 01 may toggle this channel in this mode
function toggle_ok;
    input [3:0] m;
    input [1:0] c;
    input is_a;
    begin
        case (c)
            CLS_NONPWM:
                toggle_ok = 1'b1;
            CLS_FAST:
                toggle_ok = is_a && (m == `MODE_FAST_CAP ||
                    m == `MODE_FAST_CMP);
            CLS_DUAL:
                toggle_ok = is_a && (m >= `MODE_PFC_CAP &&
                    m <= `MODE_PC_CMP);
            default:
                toggle_ok = 1'b0;
        endcase
    end
endfunction

// next compare output level
function oc_next;
    input [1:0] com;
    input [1:0] c;
    input allow;
    input match;
    input top_hit;
    input up;
    input cur;
    begin
        oc_next = cur;
        case (c)
            CLS_NONPWM: begin
                if (match) begin
                    case (com)
                        2'b01: oc_next = ~cur;
                        2'b10: oc_next = 1'b0;
                        2'b11: oc_next = 1'b1;
                        default: oc_next = cur;
                    endcase
                end
            end
            CLS_FAST: begin
                if (com[1]) begin
                    if (top_hit)
                        oc_next = ~com[0];
                    else if (match)
                        oc_next = com[0];
                end else if (com[0] && allow && match) begin
                    oc_next = ~cur;
                end
            end
            CLS_DUAL: begin
                if (com[1]) begin
                    if (match)
                        oc_next = up ? com[0] : ~com[0];
                end else if (com[0] && allow && match) begin
                    oc_next = ~cur;
                end
            end
            default:
                oc_next = cur;
        endcase
    end
endfunction

assign waveform_mode_sel = {wgm_hi_reg, wgm_lo_reg};
assign cls = mode_class(waveform_mode_sel);
assign top = mode_top(waveform_mode_sel, compare_value_a,
    capture_value);

assign at_top = (counter_value == top);
assign at_bottom = (counter_value == `BOTTOM);
assign top_evt = run_reg && at_top;
assign bottom_evt = run_reg && at_bottom && !count_up_reg;
assign max_evt = run_reg && (counter_value == `TOP_MAX);

// dual slope: a match at TOP counts as falling, at BOTTOM as rising
assign up_eff = at_top ? 1'b0 : (at_bottom ? 1'b1 : count_up_reg);

assign match_a = run_reg && !block_reg &&
    (counter_value == compare_value_a);
assign match_b = run_reg && !block_reg &&
    (counter_value == compare_value_b);

// overflow event point per mode class
assign overflow_flag = (cls == CLS_NONPWM) ? max_evt :
    (cls == CLS_FAST) ? top_evt :
    bottom_evt;

// double-buffer reload point
assign reload = (cls == CLS_FAST) ? top_evt :
    (cls == CLS_DUAL && (waveform_mode_sel == `MODE_PFC_CAP ||
    waveform_mode_sel == `MODE_PFC_CMP)) ? bottom_evt :
    (cls == CLS_DUAL) ? top_evt :
    1'b0;

assign allow_a = toggle_ok(waveform_mode_sel, cls, 1'b1);
assign allow_b = toggle_ok(waveform_mode_sel, cls, 1'b0);

// pin takeover
assign conn_a = chan_a_output_mode[1] ||
    (chan_a_output_mode[0] && allow_a);
assign conn_b = chan_b_output_mode[1] ||
    (chan_b_output_mode[0] && allow_b);
assign pin_a_out = conn_a ? compare_out_a : port_a_out;
assign pin_b_out = conn_b ? compare_out_b : port_b_out;
assign pin_a_oe = dir_a;
assign pin_b_oe = dir_b;

assign wr_ctrl_a = wr_en && (addr == `ADDR_CTRL_A);
assign wr_ctrl_b = wr_en && (addr == `ADDR_CTRL_B);
assign wr_count = wr_en && (addr == `ADDR_COUNT);
assign wr_cmp_a = wr_en && (addr == `ADDR_CMP_A);
assign wr_cmp_b = wr_en && (addr == `ADDR_CMP_B);

assign int_evt = {top_evt, match_b, match_a, overflow_flag};
assign irq = |(int_stat_reg & int_mask_reg);

// control registers
always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
        chan_a_output_mode <= 2'h0;
        chan_b_output_mode <= 2'h0;
        wgm_lo_reg <= 2'h0;
        wgm_hi_reg <= 2'h0;
        run_reg <= 1'b0;
        capture_value <= `WORD_RESET;
        int_mask_reg <= `INT_RESET;
    end else begin
        if (wr_ctrl_a) begin
            chan_a_output_mode <= wdata[`COM_A_MSB:`COM_A_LSB];
            chan_b_output_mode <= wdata[`COM_B_MSB:`COM_B_LSB];
            wgm_lo_reg <= wdata[`WGM_LO_MSB:`WGM_LO_LSB];
        end
        if (wr_ctrl_b)
            wgm_hi_reg <= wdata[`WGM_HI_MSB:`WGM_HI_LSB];
        if (wr_en && addr == `ADDR_RUN)
            run_reg <= wdata[`RUN_BIT];
        if (wr_en && addr == `ADDR_CAPTURE)
            capture_value <= wdata;
        if (wr_en && addr == `ADDR_INT_MASK)
            int_mask_reg <= wdata[3:0];
    end
end

// interrupt status: set wins over write-one-to-clear
always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
        int_stat_reg <= `INT_RESET;
    end else begin
        if (wr_en && addr == `ADDR_INT_STAT)
            int_stat_reg <= (int_stat_reg & ~wdata[3:0]) | int_evt;
        else
            int_stat_reg <= int_stat_reg | int_evt;
    end
end

// compare registers and their buffers
always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
        compare_value_a <= `WORD_RESET;
        compare_value_b <= `WORD_RESET;
        cmp_buf_a_reg <= `WORD_RESET;
        cmp_buf_b_reg <= `WORD_RESET;
    end else begin
        if (wr_cmp_a)
            cmp_buf_a_reg <= wdata;
        if (wr_cmp_b)
            cmp_buf_b_reg <= wdata;
        if (cls == CLS_NONPWM) begin
            if (wr_cmp_a)
                compare_value_a <= wdata;
            if (wr_cmp_b)
                compare_value_b <= wdata;
        end else if (reload) begin
            compare_value_a <= cmp_buf_a_reg;
            compare_value_b <= cmp_buf_b_reg;
        end
    end
end

// counter: single slope wraps at TOP, dual slope turns at the ends
always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
        counter_value <= `WORD_RESET;
        count_up_reg <= 1'b1;
        block_reg <= 1'b0;
    end else begin
        block_reg <= wr_count;
        if (wr_count) begin
            counter_value <= wdata;
        end else if (run_reg) begin
            if (cls == CLS_DUAL) begin
                if (count_up_reg) begin
                    if (at_top) begin
                        count_up_reg <= 1'b0;
                        counter_value <= counter_value - 16'h0001;
                    end else begin
                        counter_value <= counter_value + 16'h0001;
                    end
                end else begin
                    if (at_bottom) begin
                        count_up_reg <= 1'b1;
                        counter_value <= counter_value + 16'h0001;
                    end else begin
                        counter_value <= counter_value - 16'h0001;
                    end
                end
            end else begin
                count_up_reg <= 1'b1;
                if (at_top)
                    counter_value <= `BOTTOM;
                else
                    counter_value <= counter_value + 16'h0001;
            end
        end
    end
end

// compare output levels
always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
        compare_out_a <= 1'b0;
        compare_out_b <= 1'b0;
    end else begin
        // TOP action outranks a match at TOP
        compare_out_a <= oc_next(chan_a_output_mode, cls, allow_a,
            match_a, top_evt, up_eff,
            compare_out_a);
        compare_out_b <= oc_next(chan_b_output_mode, cls, allow_b,
            match_b, top_evt, up_eff,
            compare_out_b);
    end
end

// read port: data only in the cycle after the strobe
always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
        rdata <= `WORD_RESET;
    end else if (rd_en) begin
        case (addr)
            `ADDR_CTRL_A:
                rdata <= {8'h00, chan_a_output_mode,
                    chan_b_output_mode, 2'b00, wgm_lo_reg};
            `ADDR_CTRL_B:
                rdata <= {11'h000, wgm_hi_reg, 3'b000};
            `ADDR_COUNT:
                rdata <= counter_value;
            `ADDR_CAPTURE:
                rdata <= capture_value;
            `ADDR_CMP_A:
                rdata <= cmp_buf_a_reg;
            `ADDR_CMP_B:
                rdata <= cmp_buf_b_reg;
            `ADDR_INT_STAT:
                rdata <= {12'h000, int_stat_reg};
            `ADDR_INT_MASK:
                rdata <= {12'h000, int_mask_reg};
            `ADDR_RUN:
                rdata <= {15'h0000, run_reg};
            default:
                rdata <= `WORD_RESET;
        endcase
    end else begin
        rdata <= `WORD_RESET;
    end
end

endmodule

// ---- tb/timer16_checker_asserts.sv ----
// checker: pin routing, driver enable and control register readback
// assumes the register port is the only writer of the control fields
`timescale 1ns/1ps
`include "timer16_defines.vh"
module timer16_checker (
    input wire clk,
    input wire nrst,
    input wire [7:0] addr,
    input wire [15:0] wdata,
    input wire wr_en,
    input wire rd_en,
    input wire [15:0] rdata,
    input wire dir_a,
    input wire dir_b,
    input wire port_a_out,
    input wire port_b_out,
    input wire pin_a_out,
    input wire pin_a_oe,
    input wire pin_b_out,
    input wire pin_b_oe,
    input wire compare_out_a,
    input wire compare_out_b,
    input wire irq
);
    reg [7:0] ca;
    reg [1:0] hi;
    wire [3:0] m = {hi, ca[1:0]};
    // non-pwm set: normal, both clear-on-match modes, reserved
    wire np = m == 4'h0 || m == 4'h4 || m == 4'hC || m == 4'hD;
    wire tg = np || m >= 4'hE || m[3:2] == 2'b10;
    wire con_a = ca[7] || (ca[6] && tg);
    wire con_b = ca[5] || (ca[4] && np);
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ca <= 8'h00;
            hi <= 2'b00;
        end else if (wr_en && addr == `ADDR_CTRL_A) begin
            ca <= wdata[7:0] & 8'hF3;
        end else if (wr_en && addr == `ADDR_CTRL_B) begin
            hi <= wdata[4:3];
        end
    end
    default clocking dc @(posedge clk); endclocking
    default disable iff (!nrst);
    property p_route_a;
        pin_a_out == (con_a ? compare_out_a : port_a_out);
    endproperty
    property p_route_b;
        pin_b_out == (con_b ? compare_out_b : port_b_out);
    endproperty
    property p_oe_a;
        pin_a_oe == dir_a;
    endproperty
    property p_oe_b;
        pin_b_oe == dir_b;
    endproperty
    property p_rd_a;
        rd_en && addr == `ADDR_CTRL_A |=> rdata == {8'h00, ca};
    endproperty
    property p_rd_b;
        rd_en && addr == `ADDR_CTRL_B |=> rdata == {11'h000, hi, 3'h0};
    endproperty
    property p_rd_quiet;
        !rd_en |=> rdata == 16'h0000;
    endproperty
    property p_clr_only;
        np && ca[7:6] == 2'b10 |=> !$rose(compare_out_a);
    endproperty
    property p_set_only;
        np && ca[7:6] == 2'b11 |=> !$fell(compare_out_a);
    endproperty
    a_route_a: assert property (p_route_a)
        else $error("pin a routing wrong");
    a_route_b: assert property (p_route_b)
        else $error("pin b routing wrong");
    a_oe_a: assert property (p_oe_a)
        else $error("pin a enable wrong");
    a_oe_b: assert property (p_oe_b)
        else $error("pin b enable wrong");
    a_rd_a: assert property (p_rd_a)
        else $error("control a readback wrong");
    a_rd_b: assert property (p_rd_b)
        else $error("control b readback wrong");
    a_rd_quiet: assert property (p_rd_quiet)
        else $error("read data not zero");
    a_clr_only: assert property (p_clr_only)
        else $error("output set in clear mode");
    a_set_only: assert property (p_set_only)
        else $error("output cleared in set mode");
    c_rise: cover property ($rose(compare_out_a));
    c_irq: cover property ($rose(irq));
    c_rd: cover property (rd_en && addr == `ADDR_CTRL_A);
endmodule

bind timer16_waveform_mode_control timer16_checker chk (
    .clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata),
    .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .dir_a(dir_a),
    .dir_b(dir_b), .port_a_out(port_a_out), .port_b_out(port_b_out),
    .pin_a_out(pin_a_out), .pin_a_oe(pin_a_oe), .pin_b_out(pin_b_out),
    .pin_b_oe(pin_b_oe), .compare_out_a(compare_out_a),
    .compare_out_b(compare_out_b), .irq(irq)
);

// ---- tb/pin_load.sv ----
// load on one compare output pin
// assumes a weak pull-down holds the line while undriven
`timescale 1ns/1ps
module pin_load (
    input wire drv,
    input wire oe,
    output wire level
);
    assign level = oe ? drv : 1'b0;
endmodule

// ---- tb/tb_timer16_waveform_mode_control.sv ----
// self-checking bench for the timer waveform control block
// assumes one clock and read data one cycle after the strobe
`timescale 1ns/1ps
`include "timer16_defines.vh"
module tb_timer16_waveform_mode_control;
    reg clk = 1'b0;
    reg nrst = 1'b0;
    reg [7:0] addr = 8'h00;
    reg [15:0] wdata = 16'h0000;
    reg wr_en = 1'b0;
    reg rd_en = 1'b0;
    reg dir_a = 1'b1;
    reg dir_b = 1'b1;
    reg port_a_out = 1'b1;
    reg port_b_out = 1'b1;
    reg rd_pend = 1'b0;
    reg [15:0] ev;
    wire [15:0] rdata;
    wire pin_a_out, pin_a_oe, pin_b_out, pin_b_oe, irq;
    wire compare_out_a, compare_out_b, lvl_a, lvl_b;
    reg [15:0] exp_q[$];
    integer n_fail = 0;
    integer total_checks = 0;
    integer i, c, k, hi_w;

    always #5 clk = ~clk;
    timer16_waveform_mode_control uut (
        .clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata),
        .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .dir_a(dir_a),
        .dir_b(dir_b), .port_a_out(port_a_out), .port_b_out(port_b_out),
        .pin_a_out(pin_a_out), .pin_a_oe(pin_a_oe), .pin_b_out(pin_b_out),
        .pin_b_oe(pin_b_oe), .compare_out_a(compare_out_a),
        .compare_out_b(compare_out_b), .irq(irq)
    );
    pin_load load_a (.drv(pin_a_out), .oe(pin_a_oe), .level(lvl_a));
    pin_load load_b (.drv(pin_b_out), .oe(pin_b_oe), .level(lvl_b));

    function con(input [3:0] m, input [1:0] cm, input a);
        begin
            con = cm[1] || (cm[0] && (m == 4'h0 || m == 4'h4 ||
                  m == 4'hC || m == 4'hD ||
                  (a && (m >= 4'hE || m[3:2] == 2'b10))));
        end
    endfunction

    task check(input [15:0] got, input [15:0] exp);
        begin
            total_checks = total_checks + 1;
            if (got !== exp) begin
                n_fail = n_fail + 1;
                $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
            end
        end
    endtask

    always @(posedge clk) rd_pend <= rd_en;
    always @(negedge clk) begin
        if (rd_pend)
            check(rdata, exp_q.pop_front());
    end

    task wr(input [7:0] a, input [15:0] d);
        begin
            @(posedge clk);
            addr <= a;
            wdata <= d;
            wr_en <= 1'b1;
            @(posedge clk);
            wr_en <= 1'b0;
        end
    endtask
    task rd(input [7:0] a, input [15:0] e);
        begin
            exp_q.push_back(e);
            @(posedge clk);
            addr <= a;
            rd_en <= 1'b1;
            @(posedge clk);
            rd_en <= 1'b0;
        end
    endtask
    task wait_lvl(input v);
        begin
            k = 0;
            while (lvl_a !== v && k < 4000) begin
                @(negedge clk);
                k = k + 1;
            end
        end
    endtask
    task cfg(input [3:0] m, input [15:0] top, input [1:0] cm);
        begin
            wr(`ADDR_RUN, 16'h0000);
            wr(`ADDR_COUNT, 16'h0000);
            wr(`ADDR_CAPTURE, top);
            wr(`ADDR_CMP_A, 16'h0010);
            wr(`ADDR_CTRL_B, {11'h000, m[3:2], 3'h0});
            wr(`ADDR_CTRL_A, {8'h00, cm, 4'h0, m[1:0]});
            wr(`ADDR_RUN, 16'h0001);
        end
    endtask
    // one high phase then one low phase, after two settling periods
    task meas(input [15:0] h, input [15:0] p);
        begin
            repeat (2) begin
                wait_lvl(1'b0);
                wait_lvl(1'b1);
            end
            hi_w = 0;
            while (lvl_a === 1'b1 && hi_w < 4000) begin
                @(negedge clk);
                hi_w = hi_w + 1;
            end
            wait_lvl(1'b1);
            check(hi_w[15:0], h);
            hi_w = hi_w + k;
            check(hi_w[15:0], p);
        end
    endtask
    task steady(input v);
        begin
            wait_lvl(v);
            hi_w = 0;
            repeat (40) begin
                @(negedge clk);
                hi_w = hi_w + (lvl_a === v);
            end
            check(hi_w[15:0], 16'h0028);
        end
    endtask
    task chk_irq(input v);
        begin
            @(negedge clk);
            check({15'h0000, irq}, {15'h0000, v});
        end
    endtask
    task conclude;
        begin
            $display("checks=%0d mismatches=%0d", total_checks, n_fail);
            if (n_fail == 0 && total_checks > 0)
                $display("TEST PASSED");
            else
                $display("TEST FAILED");
            $finish;
        end
    endtask

    initial begin
        #500000;
        n_fail = n_fail + 1;
        conclude;
    end

    initial begin
        i = $urandom(32'h4695);
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        for (i = 8'h80; i <= 8'h90; i = i + 1)
            rd(i[7:0], 16'h0000);
        $display("done: reset values");
        for (i = 0; i < 16; i = i + 1) begin
            for (c = 0; c < 4; c = c + 1) begin
                ev = $urandom;
                wr(`ADDR_CTRL_B, {11'h000, i[3:2], 3'h0});
                wr(`ADDR_CTRL_A, {8'h00, c[1:0], c[1:0], 2'b00, i[1:0]});
                dir_a <= ev[1];
                dir_b <= ev[0];
                port_a_out <= ev[3];
                port_b_out <= ev[2];
                @(negedge clk);
                check({12'h000, pin_a_out, pin_b_out, pin_a_oe,
                       pin_b_oe}, {12'h000,
                       ev[3] & !con(i[3:0], c[1:0], 1'b1),
                       ev[2] & !con(i[3:0], c[1:0], 1'b0),
                       ev[1:0]});
            end
        end
        @(posedge clk);
        dir_a <= 1'b1;
        dir_b <= 1'b1;
        $display("done: pin routing");
        wr(`ADDR_CTRL_A, 16'hFFFF);
        rd(`ADDR_CTRL_A, 16'h00F3);
        wr(`ADDR_CTRL_B, 16'hFFFF);
        rd(`ADDR_CTRL_B, 16'h0018);
        $display("done: control readback");
        cfg(4'h1, 16'h0000, 2'b10);
        meas(16'd32, 16'd510);
        cfg(4'h2, 16'h0000, 2'b10);
        meas(16'd32, 16'd1022);
        cfg(4'h3, 16'h0000, 2'b10);
        meas(16'd32, 16'd2046);
        cfg(4'h5, 16'h0000, 2'b10);
        meas(16'd17, 16'd256);
        cfg(4'h6, 16'h0000, 2'b10);
        meas(16'd17, 16'd512);
        cfg(4'h7, 16'h0000, 2'b10);
        meas(16'd17, 16'd1024);
        cfg(4'h8, 16'h0030, 2'b10);
        meas(16'd32, 16'd96);
        cfg(4'hA, 16'h0030, 2'b11);
        meas(16'd64, 16'd96);
        cfg(4'hE, 16'h0030, 2'b11);
        meas(16'd32, 16'd49);
        cfg(4'h9, 16'h0000, 2'b01);
        meas(16'd32, 16'd64);
        cfg(4'hB, 16'h0000, 2'b01);
        meas(16'd32, 16'd64);
        cfg(4'hF, 16'h0000, 2'b01);
        meas(16'd17, 16'd34);
        cfg(4'h4, 16'h0000, 2'b01);
        meas(16'd17, 16'd34);
        cfg(4'hC, 16'h0030, 2'b01);
        meas(16'd49, 16'd98);
        $display("done: waveform modes");
        cfg(4'hE, 16'h0010, 2'b10);
        steady(1'b1);
        cfg(4'h4, 16'h0000, 2'b11);
        steady(1'b1);
        wr(`ADDR_CTRL_A, 16'h0080);
        steady(1'b0);
        // channel b set on match at 5, channel a released
        wr(`ADDR_CMP_B, 16'h0005);
        wr(`ADDR_CTRL_A, 16'h0030);
        repeat (20) @(negedge clk);
        check({15'h0000, lvl_b}, 16'h0001);
        $display("done: steady outputs");
        wr(`ADDR_INT_STAT, 16'h000F);
        wr(`ADDR_INT_MASK, 16'h0001);
        chk_irq(1'b0);
        wr(`ADDR_INT_MASK, 16'h0002);
        // a match recurs every 17 cycles
        repeat (20) @(negedge clk);
        chk_irq(1'b1);
        wr(`ADDR_RUN, 16'h0000);
        wr(`ADDR_INT_STAT, 16'h000F);
        chk_irq(1'b0);
        rd(`ADDR_INT_STAT, 16'h0000);
        cfg(4'h5, 16'h0000, 2'b10);
        wr(`ADDR_INT_MASK, 16'h0001);
        k = 0;
        while (irq !== 1'b1 && k < 600) begin
            @(negedge clk);
            k = k + 1;
        end
        chk_irq(1'b1);
        // normal mode: overflow and top at 0xFFFF, read before match b
        cfg(4'h0, 16'h0000, 2'b00);
        wr(`ADDR_COUNT, 16'hFFF0);
        wr(`ADDR_INT_STAT, 16'h000F);
        repeat (17) @(negedge clk);
        rd(`ADDR_INT_STAT, 16'h0009);
        $display("done: interrupts");
        repeat (2) @(negedge clk);
        conclude;
    end
endmodule
